// *** verilog/fsp_pkg.sv ***
// Shared constants and types for the fault, pin and switch register bank
package fsp_pkg;
	// ****************************************
	// Register offsets and layout
	// ****************************************
	localparam logic [6:0] ADDR_DIGITAL = 7'h03;
	localparam logic [6:0] ADDR_ANALOG = 7'h04;
	localparam logic [6:0] ADDR_PIN = 7'h05;
	localparam logic [6:0] ADDR_SWITCH = 7'h06;
	localparam logic [6:0] ADDR_MAP_TOP = 7'h68;
	localparam int DF_CAL_BUSY = 6;
	localparam int DF_LINK_CRC = 5;
	localparam int DF_BAD_ADDR = 4;
	localparam int DF_EDGE_CNT = 3;
	localparam int DF_IMAGE_CRC = 1;
	localparam int DF_TRIM_CRC = 0;
	localparam int AF_GAIN_RST = 7;
	localparam int AF_HV_POR = 6;
	localparam int AF_OPEN_WIRE = 4;
	localparam int AF_FAULT = 3;
	localparam int AF_OUT_OVL = 2;
	localparam int AF_IN_OVL = 1;
	localparam int AF_MUX_OV = 0;
	localparam logic [7:0] DIGITAL_FLAGS = 8'h3B;
	localparam logic [7:0] ANALOG_FLAGS = 8'hD7;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [6:0] PIN_RESET = 7'h00;
	localparam logic [6:0] SWITCH_RESET = 7'h60;
	localparam logic [6:0] SW_CHAN_ONE = 7'h60;
	localparam logic [6:0] SW_CHAN_TWO = 7'h18;
	localparam int AUX_CAL_PIN = 2;
	localparam int AUX_FAULT_PIN = 3;
	// ****************************************
	// Serial frame
	// ****************************************
	localparam logic [4:0] ADDR_BITS = 5'h08;
	localparam logic [4:0] CRC_START = 5'h10;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int GAIN_RST_US = 200;
	localparam int MUX_VALID_US = 20;
	localparam int GAIN_RST_CYCLES_DEF =
		(GAIN_RST_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MUX_VALID_CYCLES_DEF =
		(MUX_VALID_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic calRunning;
		logic imageMismatch;
		logic trimFail;
		logic hvPorTrip;
		logic openWire;
		logic wireTest;
		logic outOverload;
		logic inOverload;
		logic muxOverVolt;
	} fsp_cond_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [6:0] addr;
		logic [7:0] data;
	} fsp_access_t;
	typedef struct packed {
		logic linkCrc;
		logic badAddr;
		logic edgeCount;
	} fsp_linkerr_t;
endpackage

// *** verilog/fsp_serial_port.sv ***
// Serial slave port: frame capture, checksum, edge count, readback
`timescale 1ns/10ps
module fsp_serial_port import fsp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Serial pins
	input wire logic sclk,
	input wire logic csN,
	input wire logic sdi,
	output logic sdo,
	output logic sdoOe,
	// Register side
	output logic [6:0] lookAddr,
	input wire logic [7:0] readData,
	input wire logic addrOk,
	output fsp_access_t access,
	output fsp_linkerr_t linkErr
);
	logic [2:0] pinMeta;
	logic [2:0] pinSync;
	logic sclkPrev;
	logic csPrev;
	logic [4:0] bitCount;
	logic [23:0] frame;
	logic [7:0] crc;
	logic [7:0] outBuf;
	logic isRead;

	function automatic logic [7:0] crcStep(input logic [7:0] c,
		input logic b);
		crcStep = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
	endfunction

	wire sclkRise = pinSync[2] & ~sclkPrev;
	wire sclkFall = ~pinSync[2] & sclkPrev;
	wire csRise = pinSync[1] & ~csPrev;
	wire csFall = ~pinSync[1] & csPrev;
	wire inFrame = ~pinSync[1];
	wire dataIn = pinSync[0];
	wire [4:0] countInc = (bitCount == 5'h1F) ? bitCount : bitCount + 5'h01;
	assign sdoOe = inFrame;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta <= 3'h2;
			pinSync <= 3'h2;
			sclkPrev <= 1'b0;
			csPrev <= 1'b1;
		end else begin
			pinMeta <= {sclk, csN, sdi};
			pinSync <= pinMeta;
			sclkPrev <= pinSync[2];
			csPrev <= pinSync[1];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bitCount <= 5'h00;
			frame <= 24'h000000;
			crc <= CRC_INIT;
			lookAddr <= 7'h00;
			isRead <= 1'b0;
		end else if (csFall) begin
			bitCount <= 5'h00;
			crc <= CRC_INIT;
		end else if (inFrame && sclkRise) begin
			frame <= {frame[22:0], dataIn};
			bitCount <= countInc;
			if (bitCount < CRC_START) begin
				crc <= crcStep(crc, dataIn);
			end
			if (bitCount == ADDR_BITS - 5'h01) begin
				lookAddr <= {frame[5:0], dataIn};
				isRead <= frame[6];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sdo <= 1'b0;
			outBuf <= 8'h00;
		end else if (!inFrame) begin
			sdo <= 1'b0;
		end else if (sclkFall) begin
			if (bitCount == ADDR_BITS) begin
				sdo <= readData[7];
				outBuf <= {readData[6:0], 1'b0};
			end else begin
				sdo <= (bitCount < CRC_START) ? outBuf[7] : 1'b0;
				outBuf <= {outBuf[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			access <= '0;
			linkErr <= '0;
		end else begin
			access <= '0;
			linkErr <= '0;
			if (csRise) begin
				if (bitCount != FRAME_BITS) begin
					linkErr.edgeCount <= 1'b1;
				end else if (crc != frame[7:0]) begin
					linkErr.linkCrc <= 1'b1;
				end else if (!addrOk) begin
					linkErr.badAddr <= 1'b1;
				end else begin
					access <= '{1'b1, ~isRead, lookAddr, frame[15:8]};
				end
			end
		end
	end

	a_edge_count: assert property (@(posedge clk) disable iff (!reset_n)
		csRise && bitCount != FRAME_BITS |=> linkErr.edgeCount && !access.valid)
		else $error("edge count fault missed");
	a_crc_refuse: assert property (@(posedge clk) disable iff (!reset_n)
		csRise && bitCount == FRAME_BITS && crc != frame[7:0]
		|=> linkErr.linkCrc && !access.valid)
		else $error("checksum fault missed");
endmodule

// *** verilog/fsp_fault_regs.sv ***
// Fault status, pin data and input switch register bank with serial port
// What this block does
// - Calibration busy bit follows calibration; writes to it have no effect.
// - Aux pin two shows calibration busy when output and enabled.
// - Link checksum mismatch sets its sticky digital flag.
// - Access to an address outside the map sets bad address flag.
// - Wrong count of serial clock edges in a frame sets edge flag.
// - Register image checksum mismatch sets its sticky flag.
// - Trim store checksum failure sets its sticky flag.
// - Every flag except the selector flag in nonlatched mode stays set until the host writes one to it.
// - Input overload beyond 200 us forces default gain, sets gain flag.
// - Clearing gain flag clears only the flag, no gain restore.
// - High rail power loss sets flag; calibration runs on return.
// - Open wire detected during wire test sets its flag.
// - Combined fault is OR of all unmasked flags of both registers.
// - Aux pin three drives combined fault active low when enabled.
// - Output amplifier overload sets its flag.
// - Input amplifier overload sets its flag.
// - Selector overvoltage opens switches; restore after 20 us valid.
// - Latched mode keeps selector flag; nonlatched clears it on restore.
// - Output pins follow the written pin level bits, except aux pins two and three when mapped to busy or fault.
// - Input pins read their sampled level; writes to them ignored.
// - Seven switch bits read-write; only channel one bits reset high.
// - Channel one and two never closed together unless lockout disabled.
// - A set mask bit keeps its flag out of the combined fault.
`timescale 1ns/10ps
module fsp_fault_regs import fsp_pkg::*; #(
	parameter int GAIN_RST_CYCLES = GAIN_RST_CYCLES_DEF,
	parameter int MUX_VALID_CYCLES = MUX_VALID_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Serial port
	input wire logic sclk,
	input wire logic csN,
	input wire logic sdi,
	output logic sdo,
	output logic sdoOe,
	// Aux pins
	input wire logic [6:0] pinIn,
	output logic [6:0] pinOut,
	output logic [6:0] pinOe,
	// Analog conditions
	input wire fsp_cond_t cond,
	// Configuration from neighbouring registers
	input wire logic [6:0] pinDir,
	input wire logic [7:0] digitalMask,
	input wire logic [7:0] analogMask,
	input wire logic calFlagToPinEn,
	input wire logic faultToPinEn,
	input wire logic latchedMode,
	input wire logic dualLockoutDisable,
	// Analog control
	output logic gainForceDefault,
	output logic calStartRequest,
	output logic [6:0] switchDrive,
	output logic combinedFault
);
	localparam int GW = $clog2(GAIN_RST_CYCLES + 1);
	localparam int MW = $clog2(MUX_VALID_CYCLES + 1);

	if (GAIN_RST_CYCLES < 2 || MUX_VALID_CYCLES < 2) begin : g_bad
		$error("cycle counts must be at least two");
	end

	typedef enum logic {MUX_NORMAL, MUX_OPEN} fsp_mux_t;

	fsp_cond_t condMeta;
	fsp_cond_t condSync;
	logic [6:0] pinMeta;
	logic [6:0] pinSync;
	fsp_access_t access;
	fsp_linkerr_t linkErr;
	logic [6:0] lookAddr;
	wire addrOk = lookAddr <= ADDR_MAP_TOP;
	logic [7:0] readData;
	logic [7:0] dFlag;
	logic [7:0] aFlag;
	logic [6:0] pinLevel;
	logic [6:0] swReg;
	logic [GW-1:0] ovlCount;
	logic [MW-1:0] muxCount;
	fsp_mux_t muxState;
	fsp_mux_t next_muxState;
	logic hvPrev;
	logic [7:0] dSet;
	logic [7:0] aSet;
	logic [6:0] next_pinOut;

	function automatic logic [7:0] w1c(input logic [7:0] flags,
		input logic [7:0] set, input logic [7:0] clr, input logic [7:0] field);
		w1c = ((flags & ~clr) | set) & field;
	endfunction

	// ****************************************
	// Serial port and synchronisers
	// ****************************************
	fsp_serial_port u_port (
		.clk(clk),
		.reset_n(reset_n),
		.sclk(sclk),
		.csN(csN),
		.sdi(sdi),
		.sdo(sdo),
		.sdoOe(sdoOe),
		.lookAddr(lookAddr),
		.readData(readData),
		.addrOk(addrOk),
		.access(access),
		.linkErr(linkErr)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			condMeta <= '0;
			condSync <= '0;
			pinMeta <= 7'h00;
			pinSync <= 7'h00;
		end else begin
			condMeta <= cond;
			condSync <= condMeta;
			pinMeta <= pinIn;
			pinSync <= pinMeta;
		end
	end

	// ****************************************
	// Decoding
	// ****************************************
	wire wrEn = access.valid & access.write;
	wire wrDig = wrEn && access.addr == ADDR_DIGITAL;
	wire wrAna = wrEn && access.addr == ADDR_ANALOG;
	wire wrPin = wrEn && access.addr == ADDR_PIN;
	wire wrSw = wrEn && access.addr == ADDR_SWITCH;
	wire ovl = condSync.inOverload;
	wire ov = condSync.muxOverVolt;
	wire gainFire = ovl && ovlCount == GW'(GAIN_RST_CYCLES - 1);
	wire muxDone = muxState == MUX_OPEN && !ov
		&& muxCount == MW'(MUX_VALID_CYCLES - 1);
	wire [7:0] dClr = wrDig ? access.data : 8'h00;
	wire [7:0] autoClr = (muxDone && !latchedMode) ? 8'h01 << AF_MUX_OV
		: 8'h00;
	wire [7:0] aClr = (wrAna ? access.data : 8'h00) | autoClr;
	wire next_combined = |(dFlag & ~digitalMask & DIGITAL_FLAGS)
		| |(aFlag & ~analogMask & ANALOG_FLAGS);
	wire [6:0] pinRead = (pinLevel & pinDir) | (pinSync & ~pinDir);
	wire [7:0] digRead = dFlag
		| ({7'h00, condSync.calRunning} << DF_CAL_BUSY);
	wire [7:0] anaRead = aFlag | ({7'h00, combinedFault} << AF_FAULT);
	assign readData = !addrOk ? 8'h00
		: lookAddr == ADDR_DIGITAL ? digRead
		: lookAddr == ADDR_ANALOG ? anaRead
		: lookAddr == ADDR_PIN ? {1'b0, pinRead}
		: lookAddr == ADDR_SWITCH ? {1'b0, swReg}
		: 8'h00;
	wire chanOne = |(swReg & SW_CHAN_ONE);
	wire chanTwo = |(swReg & SW_CHAN_TWO);
	wire blockTwo = chanOne & chanTwo & ~dualLockoutDisable;
	wire [6:0] next_switchDrive = (ov || muxState == MUX_OPEN) ? 7'h00
		: swReg & ~(blockTwo ? SW_CHAN_TWO : 7'h00);
	assign pinOe = pinDir;

	// ****************************************
	// Flag sources
	// ****************************************
	always_comb begin
		dSet = 8'h00;
		dSet[DF_LINK_CRC] = linkErr.linkCrc;
		dSet[DF_BAD_ADDR] = linkErr.badAddr;
		dSet[DF_EDGE_CNT] = linkErr.edgeCount;
		dSet[DF_IMAGE_CRC] = condSync.imageMismatch;
		dSet[DF_TRIM_CRC] = condSync.trimFail;
	end

	always_comb begin
		aSet = 8'h00;
		aSet[AF_GAIN_RST] = gainFire;
		aSet[AF_HV_POR] = condSync.hvPorTrip;
		aSet[AF_OPEN_WIRE] = condSync.openWire & condSync.wireTest;
		aSet[AF_OUT_OVL] = condSync.outOverload;
		aSet[AF_IN_OVL] = ovl;
		aSet[AF_MUX_OV] = ov;
	end

	// ****************************************
	// Registers
	// ****************************************
	// sticky flags, write one clears
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dFlag <= FLAG_RESET;
			aFlag <= FLAG_RESET;
			combinedFault <= 1'b0;
		end else begin
			dFlag <= w1c(dFlag, dSet, dClr, DIGITAL_FLAGS);
			aFlag <= w1c(aFlag, aSet, aClr, ANALOG_FLAGS);
			combinedFault <= next_combined;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinLevel <= PIN_RESET;
			swReg <= SWITCH_RESET;
		end else begin
			if (wrPin) begin
				pinLevel <= (access.data[6:0] & pinDir) | (pinLevel & ~pinDir);
			end
			if (wrSw) begin
				swReg <= access.data[6:0];
			end
		end
	end

	always_comb begin
		next_pinOut = pinLevel;
		// calibration busy on aux pin two
		if (pinDir[AUX_CAL_PIN] && calFlagToPinEn) begin
			next_pinOut[AUX_CAL_PIN] = condSync.calRunning;
		end
		// fault on aux pin three, active low
		if (pinDir[AUX_FAULT_PIN] && faultToPinEn) begin
			next_pinOut[AUX_FAULT_PIN] = ~combinedFault;
		end
	end

	always_comb begin
		next_muxState = muxState;
		unique case (muxState)
			MUX_NORMAL: if (ov) next_muxState = MUX_OPEN;
			MUX_OPEN: if (muxDone) next_muxState = MUX_NORMAL;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ovlCount <= '0;
			muxCount <= '0;
			muxState <= MUX_NORMAL;
			hvPrev <= 1'b0;
			gainForceDefault <= 1'b0;
			calStartRequest <= 1'b0;
			pinOut <= PIN_RESET;
			switchDrive <= 7'h00;
		end else begin
			if (!ovl) begin
				ovlCount <= '0;
			end else if (ovlCount != GW'(GAIN_RST_CYCLES)) begin
				ovlCount <= ovlCount + 1'b1;
			end
			if (muxState == MUX_OPEN && !ov && !muxDone) begin
				muxCount <= muxCount + 1'b1;
			end else begin
				muxCount <= '0;
			end
			muxState <= next_muxState;
			hvPrev <= condSync.hvPorTrip;
			gainForceDefault <= gainFire;
			calStartRequest <= hvPrev & ~condSync.hvPorTrip;
			pinOut <= next_pinOut;
			switchDrive <= next_switchDrive;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// busy readback
	a_cal_busy_read: assert property (@(posedge clk) disable iff (!reset_n)
		lookAddr == ADDR_DIGITAL |-> readData[DF_CAL_BUSY] == condSync.calRunning)
		else $error("busy bit readback wrong");
	a_aux_two_busy: assert property (@(posedge clk) disable iff (!reset_n)
		pinDir[AUX_CAL_PIN] && calFlagToPinEn
		|=> pinOut[AUX_CAL_PIN] == $past(condSync.calRunning))
		else $error("aux pin two not showing busy");
	a_bad_addr_flag: assert property (@(posedge clk) disable iff (!reset_n)
		linkErr.badAddr |=> dFlag[DF_BAD_ADDR])
		else $error("bad address flag not set");
	a_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
		aFlag[AF_OUT_OVL] && !(wrAna && access.data[AF_OUT_OVL])
		|=> aFlag[AF_OUT_OVL])
		else $error("flag dropped without clear");
	a_gain_force: assert property (@(posedge clk) disable iff (!reset_n)
		ovl [*2] ##0 gainFire |=> gainForceDefault && aFlag[AF_GAIN_RST]
		##1 !gainForceDefault)
		else $error("gain force pulse wrong");
	a_hv_cal_start: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(condSync.hvPorTrip) |=> calStartRequest)
		else $error("no calibration after rail return");
	// aux pin three low on fault
	a_fault_pin_low: assert property (@(posedge clk) disable iff (!reset_n)
		pinDir[AUX_FAULT_PIN] && faultToPinEn && combinedFault
		|=> !pinOut[AUX_FAULT_PIN])
		else $error("fault pin not low");
	a_mux_open: assert property (@(posedge clk) disable iff (!reset_n)
		ov |=> switchDrive == 7'h00 && muxState == MUX_OPEN)
		else $error("switches not opened");
	a_chan_lockout: assert property (@(posedge clk) disable iff (!reset_n)
		!$past(dualLockoutDisable) |-> !(|(switchDrive & SW_CHAN_ONE)
		&& |(switchDrive & SW_CHAN_TWO)))
		else $error("both channels closed");
	a_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
		condSync.imageMismatch && wrDig |=> dFlag[DF_IMAGE_CRC])
		else $error("event lost to clear");
endmodule

// *** testbench/fsp_spi_host.sv ***
// Serial host model that frames register accesses for the bank
`timescale 1ns/10ps
module fsp_spi_host (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic sclk,
	output logic csN,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
	end
	// ****************************************
	// Frame checksum, MSB first
	// ****************************************
	function automatic logic [7:0] crc8(input logic [15:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction
	task automatic half();
		repeat (4) @(posedge clk);
	endtask
	// ****************************************
	// One frame, 32 ns serial clock
	// ****************************************
	// Bad checksum or edge count on request
	task automatic xfer(input logic [15:0] hdr, input int edges,
		input logic badCrc, output logic [7:0] rd);
		logic [23:0] f;
		f = {hdr, crc8(hdr) ^ {7'h00, badCrc}};
		rd = 8'h00;
		@(posedge clk);
		csN <= 1'b0;
		for (int i = 0; i < edges; i++) begin
			sdi <= f[23 - (i % 24)];
			half();
			sclk <= 1'b1;
			half();
			if (i >= 8 && i < 16) begin
				rd = {rd[6:0], sdo};
			end
			sclk <= 1'b0;
		end
		half();
		csN <= 1'b1;
		sdi <= ~sdi;
		repeat (12) @(posedge clk);
	endtask
endmodule

// *** testbench/fsp_fault_regs_tb.sv ***
// Self-checking bench for the fault, pin and switch register bank
`timescale 1ns/10ps
module fsp_fault_regs_tb import fsp_pkg::*; ;
	logic clk, reset_n, sclk, csN, sdi, sdo, sdoOe;
	logic [6:0] pinIn, pinOut, pinOe, pinDir, switchDrive, v, pinLvl;
	fsp_cond_t cond;
	logic [7:0] digitalMask, analogMask, d;
	logic calFlagToPinEn, faultToPinEn, latchedMode, dualLockoutDisable;
	logic gainForceDefault, calStartRequest, combinedFault;
	logic [31:0] lfsr = 32'hF341B90E;
	int nFail = 0;
	int nCompared = 0;
	int nCal = 0;
	int nGain = 0;
	logic [8:0] condTab [8] = '{9'h080, 9'h040, 9'h020, 9'h018, 9'h004,
		9'h002, 9'h001, 9'h010};
	logic [6:0] addrTab [8] = '{ADDR_DIGITAL, ADDR_DIGITAL, ADDR_ANALOG,
		ADDR_ANALOG, ADDR_ANALOG, ADDR_ANALOG, ADDR_ANALOG, ADDR_ANALOG};
	logic [7:0] expTab [8] = '{8'h02, 8'h01, 8'h48, 8'h18, 8'h0C, 8'h0A,
		8'h09, 8'h00};
	fsp_fault_regs #(.GAIN_RST_CYCLES(20), .MUX_VALID_CYCLES(10)) u_dut (
		.clk(clk), .reset_n(reset_n), .sclk(sclk), .csN(csN), .sdi(sdi),
		.sdo(sdo), .sdoOe(sdoOe), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .cond(cond), .pinDir(pinDir),
		.digitalMask(digitalMask), .analogMask(analogMask),
		.calFlagToPinEn(calFlagToPinEn), .faultToPinEn(faultToPinEn),
		.latchedMode(latchedMode), .dualLockoutDisable(dualLockoutDisable),
		.gainForceDefault(gainForceDefault),
		.calStartRequest(calStartRequest), .switchDrive(switchDrive),
		.combinedFault(combinedFault));
	fsp_spi_host u_host (.clk(clk), .sclk(sclk), .csN(csN), .sdi(sdi),
		.sdo(sdo));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (calStartRequest === 1'b1) nCal++;
		if (gainForceDefault === 1'b1) nGain++;
	end
	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nFail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic closeOut();
		$display("Compared %0d, failed %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] x);
		logic [7:0] r;
		u_host.xfer({1'b0, a, x}, 24, 1'b0, r);
	endtask
	task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		u_host.xfer({1'b1, a, 8'h00}, 24, 1'b0, r);
		check(r, e);
	endtask
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] swExp(input logic [6:0] s, input logic dis);
		logic lock;
		lock = |(s & SW_CHAN_ONE) && |(s & SW_CHAN_TWO) && !dis;
		return {1'b0, lock ? (s & ~SW_CHAN_TWO) : s};
	endfunction
	initial begin
		repeat (60000) @(posedge clk);
		nFail++;
		closeOut();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_n = 1'b0;
		pinIn = 7'h00;
		cond = '0;
		pinDir = 7'h00;
		digitalMask = 8'h00;
		analogMask = 8'h00;
		calFlagToPinEn = 1'b0;
		faultToPinEn = 1'b0;
		latchedMode = 1'b1;
		dualLockoutDisable = 1'b0;
		pinLvl = PIN_RESET;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		check({1'b0, switchDrive}, 8'h60);
		check({7'h00, sdoOe}, 8'h00);
		rdChk(ADDR_DIGITAL, 8'h00);
		rdChk(ADDR_ANALOG, 8'h00);
		rdChk(ADDR_SWITCH, 8'h60);
		for (int i = 0; i < 8; i++) begin
			lfsr = nextRand(lfsr);
			v = (i == 0) ? 7'h7F : lfsr[6:0];
			dualLockoutDisable <= (i == 0) ? 1'b0 : lfsr[8];
			wr(ADDR_SWITCH, {1'b0, v});
			check({1'b0, switchDrive}, swExp(v, dualLockoutDisable));
			rdChk(ADDR_SWITCH, {1'b0, v});
		end
		for (int i = 0; i < 8; i++) begin
			lfsr = nextRand(lfsr);
			pinDir <= lfsr[6:0];
			pinIn <= lfsr[14:8];
			wr(ADDR_PIN, {1'b0, lfsr[22:16]});
			pinLvl = (lfsr[22:16] & lfsr[6:0]) | (pinLvl & ~lfsr[6:0]);
			check({1'b0, pinOe}, {1'b0, lfsr[6:0]});
			check({1'b0, pinOut & lfsr[6:0]}, {1'b0, pinLvl & lfsr[6:0]});
			rdChk(ADDR_PIN, {1'b0, pinLvl & lfsr[6:0] | lfsr[14:8] & ~lfsr[6:0]});
		end
		u_host.xfer({1'b0, ADDR_SWITCH, 8'h00}, 23, 1'b0, d);
		u_host.xfer({1'b0, ADDR_SWITCH, 8'h00}, 25, 1'b0, d);
		u_host.xfer({1'b0, ADDR_SWITCH, 8'h00}, 24, 1'b1, d);
		u_host.xfer({1'b1, 7'h70, 8'h00}, 24, 1'b0, d);
		check(d, 8'h00);
		rdChk(ADDR_SWITCH, {1'b0, v});
		rdChk(ADDR_DIGITAL, 8'h38);
		rdChk(ADDR_ANALOG, 8'h08);
		pinDir <= 7'h0C;
		calFlagToPinEn <= 1'b1;
		faultToPinEn <= 1'b1;
		cond <= fsp_cond_t'(9'h100);
		repeat (8) @(posedge clk);
		check({7'h00, pinOut[AUX_CAL_PIN]}, 8'h01);
		check({7'h00, pinOut[AUX_FAULT_PIN]}, 8'h00);
		digitalMask <= 8'h38;
		repeat (6) @(posedge clk);
		check({7'h00, combinedFault}, 8'h00);
		check({7'h00, pinOut[AUX_FAULT_PIN]}, 8'h01);
		wr(ADDR_DIGITAL, 8'h40);
		rdChk(ADDR_DIGITAL, 8'h78);
		digitalMask <= 8'h00;
		cond <= '0;
		wr(ADDR_DIGITAL, 8'h00);
		rdChk(ADDR_DIGITAL, 8'h38);
		wr(ADDR_DIGITAL, 8'h08);
		rdChk(ADDR_DIGITAL, 8'h30);
		wr(ADDR_DIGITAL, 8'h30);
		rdChk(ADDR_DIGITAL, 8'h00);
		for (int i = 0; i < 8; i++) begin
			cond <= fsp_cond_t'(condTab[i]);
			repeat (6) @(posedge clk);
			cond <= '0;
			repeat (4) @(posedge clk);
			rdChk(addrTab[i], expTab[i]);
			wr(addrTab[i], expTab[i]);
			rdChk(addrTab[i], 8'h00);
		end
		cond <= fsp_cond_t'(9'h080);
		wr(ADDR_DIGITAL, 8'h02);
		rdChk(ADDR_DIGITAL, 8'h02);
		cond <= '0;
		repeat (4) @(posedge clk);
		wr(ADDR_DIGITAL, 8'h02);
		rdChk(ADDR_DIGITAL, 8'h00);
		check(8'(nCal), 8'h01);
		check(8'(nGain), 8'h00);
		cond.inOverload <= 1'b1;
		repeat (30) @(posedge clk);
		cond <= '0;
		repeat (4) @(posedge clk);
		check(8'(nGain), 8'h01);
		rdChk(ADDR_ANALOG, 8'h8A);
		wr(ADDR_ANALOG, 8'h80);
		rdChk(ADDR_ANALOG, 8'h0A);
		check(8'(nGain), 8'h01);
		wr(ADDR_ANALOG, 8'h02);
		latchedMode <= 1'b0;
		wr(ADDR_SWITCH, 8'h07);
		cond.muxOverVolt <= 1'b1;
		repeat (5) @(posedge clk);
		check({1'b0, switchDrive}, 8'h00);
		rdChk(ADDR_SWITCH, 8'h07);
		cond <= '0;
		repeat (4) @(posedge clk);
		check({1'b0, switchDrive}, 8'h00);
		repeat (12) @(posedge clk);
		check({1'b0, switchDrive}, 8'h07);
		rdChk(ADDR_ANALOG, 8'h00);
		closeOut();
	end
endmodule
